// ===== dcpr_pattern_readout.sv
`timescale 1ns/1ns
// How it works
// - Bit 0 carries pattern; others copy or zero
// - Eight-beat reads run beats 0 through 7
// - Chopped reads: A2 picks lower or upper nibble
// - A12 chops only when on-the-fly enabled
// - Bank and other address bits ignored
// - Data starts after additive plus CAS latency
// - Beat 0 is pattern LSB, beat 7 MSB
// - Location zero returns alternating 0,1 pattern
// - Enable cleared: reads and writes go to array
// - Pattern mode redirects all reads to pattern
// - Auto precharge ignored for pattern reads
// - Reset pin honoured in pattern mode
module dcpr_pattern_readout
    import dcpr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        ck_pin,
    input  wire logic        reset_n_pin,
    input  wire logic        cs_n_pin,
    input  wire logic        ras_n_pin,
    input  wire logic        cas_n_pin,
    input  wire logic        we_n_pin,
    input  wire logic [2:0]  ba_pin,
    input  wire logic [13:0] addr_pin,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic      [15:0] dq_out,
    output logic             dq_oe,
    output logic             array_read_pulse,
    output logic             array_write_pulse
);
    // Synchroniser stages for every link pin
    logic [22:0] sync1_ff;
    logic [22:0] sync2_ff;
    logic        ck_prev_ff;
    logic        ck_rise;
    logic        ck_edge;
    logic        rst_link_n;
    logic [13:0] addr_s;
    logic [2:0]  ba_s;
    dcpr_cmd_t   cmd;

    // Control and mode state
    logic [4:0]  lat_ff;
    logic        repl_ff;
    logic        mode_on_ff;
    logic [1:0]  loc_ff;
    logic [1:0]  bl_mode_ff;
    logic [31:0] count_ff;

    // Latency delay line, one slot per link clock cycle
    logic [DELAY_DEPTH-1:0] pend_v_ff;
    logic [DELAY_DEPTH-1:0] pend_chop_ff;
    logic [DELAY_DEPTH-1:0] pend_a2_ff;
    logic [4:0]  tap;
    logic        chop_now;

    // Burst engine
    logic [3:0]  rem_ff;
    logic [2:0]  beat_ff;

    // Two flip-flops before any logic looks at the pins
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync1_ff <= 23'h000000;
            sync2_ff <= 23'h000000;
        end else begin
            sync1_ff <= {ck_pin, reset_n_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin,
                         ba_pin, addr_pin};
            sync2_ff <= sync1_ff;
        end
    end

    // Edge finder on the sampled link clock
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ck_prev_ff <= 1'b0;
        end else begin
            ck_prev_ff <= sync2_ff[22];
        end
    end

    assign ck_rise    = sync2_ff[22] & ~ck_prev_ff;
    assign ck_edge    = sync2_ff[22] ^ ck_prev_ff;
    assign rst_link_n = sync2_ff[21];
    assign ba_s       = sync2_ff[16:14];
    assign addr_s     = sync2_ff[13:0];

    // Command decode, taken on each rising link clock edge
    always_comb begin
        cmd = DCPR_CMD_NONE;
        if (ck_rise && !sync2_ff[20]) begin
            case (sync2_ff[19:17])
                3'h0:    cmd = DCPR_CMD_MODE;
                3'h5:    cmd = DCPR_CMD_READ;
                3'h4:    cmd = DCPR_CMD_WRITE;
                3'h7:    cmd = DCPR_CMD_NONE;
                default: cmd = DCPR_CMD_OTHER;
            endcase
        end
    end

    // Chop decision for a pattern read
    always_comb begin
        case (bl_mode_ff)
            BL_FIXED8: chop_now = 1'b0;
            BL_OTF:    chop_now = ~addr_s[12];
            BL_FIXED4: chop_now = 1'b1;
            default:   chop_now = 1'b0;
        endcase
    end

    // Software control register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lat_ff  <= LAT_RST;
            repl_ff <= REPL_RST;
        end else if (reg_wr && reg_addr == REG_CTRL_OFS) begin
            lat_ff  <= reg_wdata[CTRL_LAT_LSB +: 5];
            repl_ff <= reg_wdata[CTRL_REPL_BIT];
        end
    end

    // Mode registers written by link commands; reset pin clears them
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_on_ff <= 1'b0;
            loc_ff     <= 2'h0;
            bl_mode_ff <= MR0_RST;
        end else if (!rst_link_n) begin
            mode_on_ff <= 1'b0;
            loc_ff     <= 2'h0;
            bl_mode_ff <= MR0_RST;
        end else if (cmd == DCPR_CMD_MODE && ba_s == MR_THREE_SEL) begin
            mode_on_ff <= addr_s[2];
            loc_ff     <= addr_s[1:0];
        end else if (cmd == DCPR_CMD_MODE && ba_s == MR_ZERO_SEL) begin
            bl_mode_ff <= addr_s[1:0];
        end
    end

    // Normal reads and writes go to the array only outside pattern mode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            array_read_pulse  <= 1'b0;
            array_write_pulse <= 1'b0;
        end else begin
            array_read_pulse  <= cmd == DCPR_CMD_READ && !mode_on_ff && rst_link_n;
            array_write_pulse <= cmd == DCPR_CMD_WRITE && !mode_on_ff && rst_link_n;
        end
    end

    // Pattern reads enter the delay line; precharge, bank and column bits other than A2 and A12 unused
    always_ff @(posedge mclk) begin
        if (sys_rst || !rst_link_n) begin
            pend_v_ff    <= '0;
            pend_chop_ff <= '0;
            pend_a2_ff   <= '0;
        end else if (ck_rise) begin
            pend_v_ff    <= {pend_v_ff[DELAY_DEPTH-2:0],
                             cmd == DCPR_CMD_READ && mode_on_ff};
            pend_chop_ff <= {pend_chop_ff[DELAY_DEPTH-2:0], chop_now};
            pend_a2_ff   <= {pend_a2_ff[DELAY_DEPTH-2:0], addr_s[2]};
        end
    end

    // Latency of zero is treated as one cycle
    assign tap = (lat_ff == 5'h00) ? 5'h00 : 5'(lat_ff - 5'h01);

    // Burst engine: one beat per link clock edge after the latency
    always_ff @(posedge mclk) begin
        if (sys_rst || !rst_link_n) begin
            rem_ff  <= 4'h0;
            beat_ff <= 3'h0;
            dq_out  <= 16'h0000;
            dq_oe   <= 1'b0;
        end else if (ck_rise && pend_v_ff[tap]) begin
            // Chop picks a nibble with A2; full burst always from beat 0
            if (pend_chop_ff[tap]) begin
                rem_ff  <= BEATS_CHOP - 4'h1;
                beat_ff <= {pend_a2_ff[tap], 2'h1};
                dq_out  <= lane_word(beat_bit({pend_a2_ff[tap], 2'h0}));
            end else begin
                rem_ff  <= BEATS_FULL - 4'h1;
                beat_ff <= 3'h1;
                dq_out  <= lane_word(beat_bit(3'h0));
            end
            dq_oe <= 1'b1;
        end else if (ck_edge && rem_ff != 4'h0) begin
            rem_ff  <= rem_ff - 4'h1;
            beat_ff <= beat_ff + 3'h1;
            dq_out  <= lane_word(beat_bit(beat_ff));
            dq_oe   <= 1'b1;
        end else if (ck_edge) begin
            dq_oe  <= 1'b0;
            dq_out <= 16'h0000;
        end
    end

    // Pattern bit for a beat; reserved locations return zero
    function automatic logic beat_bit(input logic [2:0] idx);
        beat_bit = (loc_ff == LOC_PATTERN) ? PATTERN_LOC0[idx] : 1'b0;
    endfunction

    // Both lanes carry the bit on bit 0, copied up or zeroed
    function automatic logic [15:0] lane_word(input logic b);
        logic [7:0] lane;
        lane = repl_ff ? {8{b}} : {7'h00, b};
        lane_word = {lane, lane};
    endfunction

    // Count of pattern reads served
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_ff <= 32'h00000000;
        end else if (ck_rise && pend_v_ff[tap] && rst_link_n) begin
            count_ff <= count_ff + 32'h00000001;
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL_OFS:   reg_rdata <= {23'h000000, repl_ff, 3'h0, lat_ff};
                REG_STATUS_OFS: reg_rdata <= {28'h0000000, rem_ff != 4'h0 || dq_oe,
                                              loc_ff, mode_on_ff};
                REG_COUNT_OFS:  reg_rdata <= count_ff;
                default:        reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule

// ===== dcpr_pkg.sv
package dcpr_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] REG_CTRL_OFS   = 4'h0;
    localparam logic [3:0] REG_STATUS_OFS = 4'h4;
    localparam logic [3:0] REG_COUNT_OFS  = 4'h8;
    // Control field positions and reset values
    localparam int         CTRL_LAT_LSB   = 0;
    localparam int         CTRL_REPL_BIT  = 8;
    localparam logic [4:0] LAT_RST        = 5'h06;
    localparam logic       REPL_RST       = 1'b1;
    // Status field positions
    localparam int         STAT_MODE_BIT  = 0;
    localparam int         STAT_LOC_LSB   = 1;
    localparam int         STAT_BUSY_BIT  = 3;
    // Mode register select codes on the bank address
    localparam logic [2:0] MR_ZERO_SEL    = 3'h0;
    localparam logic [2:0] MR_THREE_SEL   = 3'h3;
    // Mode register zero burst field
    localparam logic [1:0] BL_FIXED8      = 2'h0;
    localparam logic [1:0] BL_OTF         = 2'h1;
    localparam logic [1:0] BL_FIXED4      = 2'h2;
    localparam logic [1:0] MR0_RST        = 2'h0;
    // Pattern for location zero, beat 0 in the least significant bit
    localparam logic [7:0] PATTERN_LOC0   = 8'hAA;
    localparam logic [1:0] LOC_PATTERN    = 2'h0;
    // Burst lengths in beats
    localparam logic [3:0] BEATS_FULL     = 4'h8;
    localparam logic [3:0] BEATS_CHOP     = 4'h4;
    localparam int         DELAY_DEPTH    = 32;
    // Decoded link command
    typedef enum {DCPR_CMD_NONE, DCPR_CMD_MODE, DCPR_CMD_READ, DCPR_CMD_WRITE,
                  DCPR_CMD_OTHER} dcpr_cmd_t;
endpackage

// ===== dcpr_props.sv
`timescale 1ns/1ns
module dcpr_props (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        reset_n_pin,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe,
    input wire logic        array_read_pulse,
    input wire logic        array_write_pulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Burst start: output enable goes from low to high
    sequence burst_start;
        !dq_oe ##1 dq_oe;
    endsequence
    // Upper lane bits either copy bit 0 or stay low
    sequence lane_ok;
        dq_out[7:1] == 7'h00 || dq_out[7:1] == {7{dq_out[0]}};
    endsequence
    // A beat holds for eight cycles unless the burst ends
    sequence beat_held;
        (!dq_oe || $stable(dq_out)) [*8];
    endsequence
    // No further write pulse for eight cycles
    sequence wr_quiet;
        !array_write_pulse [*8];
    endsequence
    lane_fill_a: assert property (dq_oe |-> lane_ok)
        else $error("lane bits neither copied nor zero");
    lane_pair_a: assert property (dq_oe |-> dq_out[15:8] == dq_out[7:0])
        else $error("byte lanes differ");
    first_beat_a: assert property (burst_start |-> dq_out == 16'h0000)
        else $error("first beat not zero");
    burst_len_a: assert property (burst_start |-> dq_oe [*8])
        else $error("burst too short");
    beat_hold_a: assert property (dq_oe && $changed(dq_out) |=> beat_held)
        else $error("beat changed too soon");
    idle_low_a: assert property (!dq_oe |-> dq_out == 16'h0000)
        else $error("data driven while idle");
    rdata_slot_a: assert property (reg_rdata != 32'h0000_0000 |-> $past(reg_rd))
        else $error("read data outside its slot");
    pin_reset_a: assert property (!reset_n_pin [*4] |=> !dq_oe && !array_read_pulse)
        else $error("reset pin not honoured");
    rd_pulse_a: assert property (array_read_pulse |=> !array_read_pulse [*8])
        else $error("array read pulse too long");
    wr_pulse_a: assert property (array_write_pulse |-> !array_read_pulse ##1 wr_quiet)
        else $error("array write pulse malformed");
endmodule
bind dcpr_pattern_readout dcpr_props i_props (.mclk, .sys_rst, .reset_n_pin, .reg_rd,
    .reg_rdata, .dq_out, .dq_oe, .array_read_pulse, .array_write_pulse);

// ===== dcpr_ctrl_model.sv
`timescale 1ns/1ns
module dcpr_ctrl_model (
    input  wire logic        mclk,
    output logic             ck_pin,
    output logic             cs_n_pin,
    output logic             ras_n_pin,
    output logic             cas_n_pin,
    output logic             we_n_pin,
    output logic [2:0]       ba_pin,
    output logic [13:0]      addr_pin
);
    // Command clock runs free, phase unrelated to mclk
    initial begin
        {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 4'hF;
        ba_pin = 3'h0;
        addr_pin = 14'h0000;
        ck_pin = 1'b0;
        #7;
        forever #80 ck_pin = ~ck_pin;
    end
    // One command around a rising ck; released lines show the inverse value
    task automatic issue(input logic [2:0] op, input logic [2:0] ba, input logic [13:0] a);
        @(negedge ck_pin);
        @(posedge mclk);
        {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= {1'b0, op};
        ba_pin <= ba;
        addr_pin <= a;
        @(negedge ck_pin);
        @(posedge mclk);
        {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= 4'hF;
        ba_pin <= ~ba;
        addr_pin <= ~a;
    endtask
    // Idle ck cycles covering precharge, mode and recovery waits
    task automatic gap(input int n);
        repeat (n) @(posedge ck_pin);
    endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ns
module testbench
    import dcpr_pkg::*;
;
    logic        mclk, sys_rst, reset_n_pin, reg_wr, reg_rd, dq_oe;
    logic        ck_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
    logic        array_read_pulse, array_write_pulse, repl;
    logic [2:0]  ba_pin;
    logic [13:0] addr_pin;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] dq_out;
    logic [15:0] beats[$];
    int          n_errors, tests_run, cyc, n_ard, n_awr, t_cmd, t_first, lat;
    dcpr_pattern_readout i_dcpr_pattern_readout (
        .mclk              (mclk),
        .sys_rst           (sys_rst),
        .ck_pin            (ck_pin),
        .reset_n_pin       (reset_n_pin),
        .cs_n_pin          (cs_n_pin),
        .ras_n_pin         (ras_n_pin),
        .cas_n_pin         (cas_n_pin),
        .we_n_pin          (we_n_pin),
        .ba_pin            (ba_pin),
        .addr_pin          (addr_pin),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_rdata         (reg_rdata),
        .dq_out            (dq_out),
        .dq_oe             (dq_oe),
        .array_read_pulse  (array_read_pulse),
        .array_write_pulse (array_write_pulse)
    );
    dcpr_ctrl_model i_ctrl (
        .mclk      (mclk),
        .ck_pin    (ck_pin),
        .cs_n_pin  (cs_n_pin),
        .ras_n_pin (ras_n_pin),
        .cas_n_pin (cas_n_pin),
        .we_n_pin  (we_n_pin),
        .ba_pin    (ba_pin),
        .addr_pin  (addr_pin)
    );
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Cycle count, pulse tallies, first-beat stamp and hang guard
    always @(posedge mclk) begin
        cyc++;
        n_ard += int'(array_read_pulse === 1'b1);
        n_awr += int'(array_write_pulse === 1'b1);
        if (dq_oe === 1'b1 && t_first == 0) t_first = cyc;
        if (cyc == 40000) begin
            n_errors++;
            close_out();
        end
    end
    always @(posedge ck_pin) if (cs_n_pin === 1'b0) t_cmd = cyc;
    // Sample each beat mid-way between ck edges
    always @(ck_pin) begin
        repeat (10) @(posedge mclk);
        if (dq_oe === 1'b1) beats.push_back(dq_out);
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", exp, reg_rdata);
    endtask
    // Pattern read; beat i must carry pattern bit s+i on every lane
    task automatic burst(input logic [13:0] a, input int s, input int n);
        logic [31:0] exp_beat;
        beats = {};
        t_first = 0;
        i_ctrl.issue(3'h5, 3'h5, a);
        i_ctrl.gap(lat + 5);
        check("beat count", 32'(n), 32'(beats.size()));
        foreach (beats[i]) begin
            exp_beat = PATTERN_LOC0[s+i] ? (repl ? 32'h0000FFFF : 32'h00000101) : 32'h00000000;
            check("beat", exp_beat, 32'(beats[i]));
        end
        // A read outside pattern mode must start no burst at all
        if (n == 0) begin
            check("no burst", 32'h00000000, 32'(t_first));
        end else begin
            check("latency", 32'h1, 32'((t_first - t_cmd) inside {[lat*40-1:lat*40+5]}));
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {sys_rst, reset_n_pin, reg_wr, reg_rd} = 4'hC;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_reg(REG_CTRL_OFS, 32'(LAT_RST) | (32'(REPL_RST) << CTRL_REPL_BIT));
        rd_reg(REG_STATUS_OFS, 32'h0);
        rd_reg(4'hC, 32'h0);
        wr_reg(REG_CTRL_OFS, 32'h4);
        rd_reg(REG_CTRL_OFS, 32'h4);
        {repl, lat} = {1'b0, 32'd4};
        $display("registers done");
        i_ctrl.gap(2);
        i_ctrl.issue(3'h5, 3'h0, 14'h0);
        i_ctrl.issue(3'h4, 3'h0, 14'h0);
        i_ctrl.issue(3'h0, 3'h0, 14'h1);
        i_ctrl.gap(4);
        i_ctrl.issue(3'h0, 3'h3, 14'h4);
        i_ctrl.gap(4);
        rd_reg(REG_STATUS_OFS, 32'h1);
        burst(14'h3FF8, 0, 8);
        burst(14'h2FF8, 0, 4);
        burst(14'h2FFC, 4, 4);
        wr_reg(REG_CTRL_OFS, 32'h104);
        repl = 1'b1;
        burst(14'h1000, 0, 8);
        check("array reads", 32'h1, 32'(n_ard));
        rd_reg(REG_COUNT_OFS, 32'h4);
        $display("pattern reads done");
        i_ctrl.gap(4);
        i_ctrl.issue(3'h0, 3'h3, 14'h0);
        i_ctrl.gap(4);
        burst(14'h1000, 0, 0);
        i_ctrl.issue(3'h4, 3'h0, 14'h0);
        i_ctrl.gap(2);
        check("array reads", 32'h2, 32'(n_ard));
        check("array writes", 32'h2, 32'(n_awr));
        i_ctrl.issue(3'h0, 3'h0, 14'h2);
        i_ctrl.gap(4);
        i_ctrl.issue(3'h0, 3'h3, 14'h4);
        i_ctrl.gap(4);
        burst(14'h1004, 4, 4);
        i_ctrl.gap(2);
        @(posedge mclk);
        reset_n_pin <= 1'b0;
        repeat (8) @(posedge mclk);
        reset_n_pin <= 1'b1;
        rd_reg(REG_STATUS_OFS, 32'h0);
        i_ctrl.issue(3'h0, 3'h3, 14'h4);
        i_ctrl.gap(4);
        burst(14'h0000, 0, 8);
        $display("exit and reset done");
        close_out();
    end
endmodule
